/* File: pkg/rrc_pkg.sv */
/*
 * rrc_pkg: shared constants and carrier types for the reference output
 * refresh control block.
 * assumes a 200 MHz system clock; no other package is needed.
 */
package rrc_pkg;
    localparam int CODE_W = 10;
    localparam int NUM_CH = 8;
    localparam int CH_W = 3;
    localparam int LEVEL_W = 16;
    localparam int PROD_W = LEVEL_W + CODE_W + 1;
    // code / 1024 is a right shift by the code width
    localparam int FULL_SCALE_SHIFT = 10;
    localparam int CLK_MHZ = 200;
    // internal refresh oscillator, roughly 21 kHz
    localparam int OSC_HZ = 21000;
    localparam int OSC_HALF_CYC = (CLK_MHZ * 1000000) / (2 * OSC_HZ);
    // capture-to-output bounds, microseconds
    localparam int LAT_MIN_US = 48;
    localparam int LAT_MAX_US = 380;
    localparam int LAT_MIN_CYC = LAT_MIN_US * CLK_MHZ;
    localparam int LAT_MAX_CYC = LAT_MAX_US * CLK_MHZ;
    // largest move per refresh cycle, in level units (2 V at 1 mV/lsb)
    localparam logic [LEVEL_W-1:0] STEP_MAX = 16'h07d0;
    localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
    localparam logic [LEVEL_W-1:0] LEVEL_RST = 16'h0000;
    localparam logic [CH_W-1:0] CH_FIRST = 3'h0;
    localparam logic [CH_W-1:0] CH_LAST = 3'h7;

    typedef enum logic [1:0] {
        RRC_ST_IDLE = 2'b00,
        RRC_ST_XFER = 2'b01,
        RRC_ST_HOLD = 2'b10
    } rrc_state_t;

    typedef struct packed {
        logic wr_en;
        logic [CH_W-1:0] wr_ch;
        logic [CODE_W-1:0] wr_code;
    } rrc_wr_t;

    typedef struct packed {
        logic [LEVEL_W-1:0] high;
        logic [LEVEL_W-1:0] low;
    } rrc_ref_t;

    typedef struct packed {
        logic o;
        logic oe;
    } rrc_pin_out_t;
endpackage : rrc_pkg

/* File: verilog/rrc_pin_sync.sv */
/*
 * rrc_pin_sync: three-stage input synchroniser with agreement filter.
 * assumes the input is asynchronous to clk_i.
 */
`timescale 1ns/100ps
module rrc_pin_sync (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic async_i,
    output logic level_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } rrc_sync_state_t;

    rrc_sync_state_t st_q;
    rrc_sync_state_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = async_i;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // only stages two and three decide; stage one feeds stage two alone
        if (st_q.s2 == st_q.s3) begin
            st_d.lvl = st_q.s3;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_o = st_q.lvl;
endmodule : rrc_pin_sync

/* File: verilog/rrc_refresh_ctrl.sv */
/*
 * rrc_refresh_ctrl: refresh sequencing and clock-source control for an
 * eight-channel 10-bit reference generator.
 * assumes channel codes arrive already decoded from the serial side as a
 * one-cycle write strobe; reference levels are digital words.
 */
`timescale 1ns/100ps
module rrc_refresh_ctrl (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire rrc_pkg::rrc_wr_t wr_i,
    input wire rrc_pkg::rrc_ref_t ref_i,
    input wire logic clock_source_select_i,
    input wire logic refresh_clock_pin_i,
    output logic refresh_clock_pin_o,
    output logic refresh_clock_pin_oe_o,
    output logic refresh_switch_closed_o,
    output logic [rrc_pkg::CH_W-1:0] out_ch_o,
    output logic [rrc_pkg::LEVEL_W-1:0] out_level_o,
    output logic out_valid_o,
    output logic cycle_done_o
);
    localparam int HALF_W = 16;
    localparam logic [HALF_W-1:0] HALF_LAST =
        HALF_W'(rrc_pkg::OSC_HALF_CYC - 1);

    typedef struct packed {
        logic [rrc_pkg::NUM_CH-1:0][rrc_pkg::CODE_W-1:0] code;
        logic [rrc_pkg::NUM_CH-1:0][rrc_pkg::LEVEL_W-1:0] level;
        logic [HALF_W-1:0] div_cnt;
        logic osc;
        logic started;
        logic rclk_prev;
        rrc_pkg::rrc_state_t state;
        logic [rrc_pkg::CH_W-1:0] ch;
        logic [rrc_pkg::CH_W-1:0] out_ch;
        logic [rrc_pkg::LEVEL_W-1:0] out_level;
        logic out_valid;
        logic cycle_done;
        logic sw_closed;
        logic pin_oe;
    } rrc_ctrl_state_t;

    rrc_ctrl_state_t st_q;
    rrc_ctrl_state_t st_d;
    logic ext_clk;
    logic sel_ext;
    logic rclk;
    logic rclk_fall;
    logic rclk_rise;
    logic [rrc_pkg::LEVEL_W-1:0] span;
    logic [rrc_pkg::PROD_W-1:0] prod;
    logic [rrc_pkg::LEVEL_W-1:0] target;
    logic [rrc_pkg::LEVEL_W-1:0] cur;
    logic [rrc_pkg::LEVEL_W-1:0] diff;

    rrc_pin_sync u_sync_clk (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(refresh_clock_pin_i),
        .level_o(ext_clk)
    );

    rrc_pin_sync u_sync_sel (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(clock_source_select_i),
        .level_o(sel_ext)
    );

    // selected refresh clock and its edges
    assign rclk = sel_ext ? ext_clk : st_q.osc;
    assign rclk_fall = st_q.rclk_prev & ~rclk;
    assign rclk_rise = ~st_q.rclk_prev & rclk;

    // target level for the channel being visited
    assign span = (ref_i.high > ref_i.low) ?
        rrc_pkg::LEVEL_W'(ref_i.high - ref_i.low) : rrc_pkg::LEVEL_RST;
    assign prod = rrc_pkg::PROD_W'(span) *
        rrc_pkg::PROD_W'(st_q.code[st_q.ch]);
    assign target = rrc_pkg::LEVEL_W'(ref_i.low +
        rrc_pkg::LEVEL_W'(prod >> rrc_pkg::FULL_SCALE_SHIFT));
    assign cur = st_q.level[st_q.ch];
    assign diff = (target > cur) ? rrc_pkg::LEVEL_W'(target - cur) :
        rrc_pkg::LEVEL_W'(cur - target);

    always_comb begin
        st_d = st_q;
        st_d.cycle_done = 1'b0;
        st_d.rclk_prev = rclk;

        // settings store, one independent word per output
        if (wr_i.wr_en) begin
            st_d.code[wr_i.wr_ch] = wr_i.wr_code;
        end

        // internal oscillator free-runs from the system clock
        if (st_q.div_cnt == HALF_LAST) begin
            st_d.div_cnt = '0;
            st_d.osc = ~st_q.osc;
            st_d.started = 1'b1;
        end else begin
            st_d.div_cnt = HALF_W'(st_q.div_cnt + 1'b1);
        end

        // pin stays undriven until the first oscillator period begins;
        // released the cycle after sel_ext selects the pin as an input
        st_d.pin_oe = st_q.started & ~sel_ext;

        case (st_q.state)
            rrc_pkg::RRC_ST_IDLE: begin
                st_d.sw_closed = 1'b0;
                if (rclk_fall) begin
                    st_d.state = rrc_pkg::RRC_ST_XFER;
                end
            end
            rrc_pkg::RRC_ST_XFER: begin
                // one channel per falling edge; slew-limited move
                st_d.sw_closed = 1'b1;
                if (diff > rrc_pkg::STEP_MAX) begin
                    if (target > cur) begin
                        st_d.level[st_q.ch] =
                            rrc_pkg::LEVEL_W'(cur + rrc_pkg::STEP_MAX);
                    end else begin
                        st_d.level[st_q.ch] =
                            rrc_pkg::LEVEL_W'(cur - rrc_pkg::STEP_MAX);
                    end
                end else begin
                    st_d.level[st_q.ch] = target;
                end
                st_d.out_ch = st_q.ch;
                st_d.out_level = st_d.level[st_q.ch];
                st_d.out_valid = 1'b1;
                st_d.state = rrc_pkg::RRC_ST_HOLD;
            end
            rrc_pkg::RRC_ST_HOLD: begin
                if (rclk_rise) begin
                    // switches open; advance fixed channel order
                    st_d.sw_closed = 1'b0;
                    st_d.state = rrc_pkg::RRC_ST_IDLE;
                    if (st_q.ch == rrc_pkg::CH_LAST) begin
                        st_d.ch = rrc_pkg::CH_FIRST;
                        st_d.cycle_done = 1'b1;
                    end else begin
                        st_d.ch = rrc_pkg::CH_W'(st_q.ch + 1'b1);
                    end
                end else if (rclk_fall) begin
                    // missed rise (glitchy external clock): transfer the same channel again
                    st_d.state = rrc_pkg::RRC_ST_XFER;
                end
            end
            default: begin
                st_d.state = rrc_pkg::RRC_ST_IDLE;
                st_d.sw_closed = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= '0;
            st_q.state <= rrc_pkg::RRC_ST_IDLE;
            st_q.ch <= rrc_pkg::CH_FIRST;
            st_q.rclk_prev <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign refresh_clock_pin_o = st_q.osc;
    assign refresh_clock_pin_oe_o = st_q.pin_oe;
    assign refresh_switch_closed_o = st_q.sw_closed;
    assign out_ch_o = st_q.out_ch;
    assign out_level_o = st_q.out_level;
    assign out_valid_o = st_q.out_valid;
    assign cycle_done_o = st_q.cycle_done;
endmodule : rrc_refresh_ctrl

/* File: tb/rrc_ext_clock.sv */
/* rrc_ext_clock: far-side clock source, line-rate style.
   assumes en_i from the bench; the clock stands low while disabled. */
`timescale 1ns/100ps
module rrc_ext_clock #(
    parameter realtime HALF_NS = 97.3
) (
    input wire logic en_i,
    output logic clk_o
);
    // odd half period keeps phase unrelated to the system clock
    initial begin
        clk_o = 1'b0;
        forever begin
            #(HALF_NS);
            clk_o = en_i ? ~clk_o : 1'b0;
        end
    end
endmodule : rrc_ext_clock

/* File: tb/rrc_refresh_ctrl_properties.sv */
/* rrc_refresh_ctrl_properties: port checker for the refresh block.
   assumes it is bound to rrc_refresh_ctrl; one clock domain. */
`timescale 1ns/100ps
module rrc_refresh_ctrl_properties (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire rrc_pkg::rrc_ref_t ref_i,
    input wire logic clock_source_select_i,
    input wire logic refresh_clock_pin_oe_o,
    input wire logic refresh_switch_closed_o,
    input wire logic [rrc_pkg::CH_W-1:0] out_ch_o,
    input wire logic [rrc_pkg::LEVEL_W-1:0] out_level_o,
    input wire logic out_valid_o,
    input wire logic cycle_done_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // cycles with the switches open; a stalled refresh shows up here
    int open_q;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            open_q <= 0;
        end else if (refresh_switch_closed_o) begin
            open_q <= 0;
        end else begin
            open_q <= open_q + 1;
        end
    end
    chk_pin_idle_start: assert property ($fell(sys_rst_i) |->
        !refresh_clock_pin_oe_o && !out_valid_o) else $error("pin driven");
    chk_ext_no_drive: assert property (clock_source_select_i [*8]
        |-> !refresh_clock_pin_oe_o) else $error("pin driven in ext");
    chk_xfer_valid: assert property ($rose(refresh_switch_closed_o)
        |-> out_valid_o) else $error("transfer without valid");
    chk_ch_order: assert property ($rose(refresh_switch_closed_o)
        && $past(out_valid_o) |-> out_ch_o == $past(out_ch_o) + 3'h1)
        else $error("channel order");
    chk_done_ch7: assert property ($rose(cycle_done_o) |->
        out_ch_o == 3'h7 && !refresh_switch_closed_o) else $error("done");
    chk_done_pulse: assert property (cycle_done_o |=>
        !cycle_done_o) else $error("done too long");
    chk_out_hold: assert property (!$rose(refresh_switch_closed_o)
        |-> $stable(out_level_o) && $stable(out_ch_o))
        else $error("out moved");
    chk_level_cap: assert property ($rose(refresh_switch_closed_o)
        && ref_i.high > ref_i.low |-> out_level_o <= ref_i.high)
        else $error("level above high ref");
    chk_slot_latency: assert property (open_q <= rrc_pkg::LAT_MAX_CYC)
        else $error("refresh stalled");
    cov_done: cover property ($rose(cycle_done_o));
    cov_oe: cover property ($rose(refresh_clock_pin_oe_o));
    cov_ext: cover property ($rose(refresh_switch_closed_o) &&
        clock_source_select_i);
endmodule : rrc_refresh_ctrl_properties
bind rrc_refresh_ctrl rrc_refresh_ctrl_properties chk (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .ref_i(ref_i),
    .clock_source_select_i(clock_source_select_i),
    .refresh_clock_pin_oe_o(refresh_clock_pin_oe_o),
    .refresh_switch_closed_o(refresh_switch_closed_o),
    .out_ch_o(out_ch_o), .out_level_o(out_level_o),
    .out_valid_o(out_valid_o), .cycle_done_o(cycle_done_o));

/* File: tb/rrc_refresh_ctrl_tb.sv */
/* rrc_refresh_ctrl_tb: self-checking bench for the refresh block.
   assumes rrc_ext_clock as far-side source and the bound checker. */
`timescale 1ns/100ps
module rrc_refresh_ctrl_tb;
    logic clk_i, sys_rst_i, sel, ext_en, ext_clk, pin_o, oe, sw, valid, done;
    logic [rrc_pkg::CH_W-1:0] ch;
    logic [rrc_pkg::LEVEL_W-1:0] lvl;
    rrc_pkg::rrc_wr_t wr;
    rrc_pkg::rrc_ref_t refs;
    int failures, tests_run, cyc;
    rrc_ext_clock ext (.en_i(ext_en), .clk_o(ext_clk));
    rrc_refresh_ctrl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wr_i(wr),
        .ref_i(refs), .clock_source_select_i(sel),
        .refresh_clock_pin_i(oe ? pin_o : ext_clk),
        .refresh_clock_pin_o(pin_o),
        .refresh_clock_pin_oe_o(oe), .refresh_switch_closed_o(sw),
        .out_ch_o(ch), .out_level_o(lvl), .out_valid_o(valid),
        .cycle_done_o(done));
    task automatic close_out();
        $display("compares %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask : tick
    task automatic wait_sw(input logic v, input int lim);
        for (int n = 0; n < lim && sw !== v; n++) tick();
        check(16'(sw), 16'(v));
    endtask : wait_sw
    task automatic wait_done();
        for (int n = 0; n < 1000 && done !== 1'b1; n++) tick();
        check(16'(done), 16'h1);
    endtask : wait_done
    task automatic put(input int c, input logic [9:0] code);
        @(negedge clk_i);
        wr = '{1'b1, 3'(c), code};
        @(negedge clk_i);
        wr.wr_en = 1'b0;
    endtask : put
    function automatic logic [9:0] code_of(input int i);
        return (i == 7) ? 10'h3ff : 10'(i * 73);
    endfunction : code_of
    task automatic t_internal();
        int n;
        repeat (4000) tick();
        check(16'(oe), 16'h0);
        check(16'(valid), 16'h0);
        for (n = 0; n < 1500 && pin_o !== 1'b1; n++) tick();
        for (n = 0; n < 6000 && pin_o !== 1'b0; n++) tick();
        check(16'(n), 16'(rrc_pkg::OSC_HALF_CYC));
        check(16'(oe), 16'h1);
        wait_sw(1'b1, 10);
        check(16'(valid), 16'h1);
        check(16'(ch), 16'h0);
        check(lvl, 16'h0100);
    endtask : t_internal
    task automatic t_slots();
        @(negedge clk_i);
        sel = 1'b1;
        repeat (10) tick();
        check(16'(oe), 16'h0);
        ext_en = 1'b1;
        for (int i = 0; i < 8; i++) put(i, code_of(i));
        wait_done();
        for (int i = 0; i < 8; i++) begin
            wait_sw(1'b1, 100);
            check(16'(ch), 16'(i));
            check(lvl, 16'h0100 + 16'(code_of(i)));
            check(16'(ext_clk), 16'h0);
            wait_sw(1'b0, 100);
            check(16'(ext_clk), 16'h1);
        end
        for (int n = 0; n < 5 && done !== 1'b1; n++) tick();
        check(16'(done), 16'h1);
    endtask : t_slots
    task automatic t_step();
        wait_done();
        wait_sw(1'b1, 100);
        @(negedge clk_i);
        refs = '{16'hc000, 16'h0000};
        put(0, 10'h3ff);
        wait_done();
        wait_sw(1'b1, 100);
        check(lvl, 16'h08d0);
        wait_done();
        wait_sw(1'b1, 100);
        check(lvl, 16'h10a0);
        // downward move is slew-limited as well
        put(0, 10'h000);
        wait_done();
        wait_sw(1'b1, 100);
        check(lvl, 16'h08d0);
    endtask : t_step
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        cyc = 0;
        forever begin
            @(posedge clk_i);
            cyc++;
            if (cyc > 20000) begin
                failures++;
                close_out();
            end
        end
    end
    initial begin
        failures = 0;
        tests_run = 0;
        sel = 1'b0;
        ext_en = 1'b0;
        wr = '0;
        refs = '{16'h0500, 16'h0100};
        sys_rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        t_internal();
        t_slots();
        t_step();
        close_out();
    end
endmodule : rrc_refresh_ctrl_tb
